// *** dpll_power_and_loop_mode_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpll_power_and_loop_mode_control_test;
  import dplpc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, history_valid, loop_tw_in_valid;
  logic phase_lock_raw, freq_lock_raw, manual_ref_b, phase_locked, freq_locked;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, loop_state;
  logic [2:0] hsize, switchover_mode;
  logic [23:0] history_tw, freerun_tw, loop_tw, osc_tw;
  logic [7:0] pdv;
  wire logic hready;
  int n_errors, tests_run;
  localparam logic [31:0] PD = {18'h0, DPLPC_ADDR_POWER_DOWN};
  localparam logic [31:0] LM = {18'h0, DPLPC_ADDR_LOOP_MODE};
  assign hready = hreadyout;
  dplpc_top i_dplpc_top (.*, .soft_reset(pdv[7]), .pd_controlled_oscillator(pdv[6]),
    .pd_system_clock_input(pdv[5]), .pd_reference_inputs(pdv[4]),
    .pd_time_to_digital_converter(pdv[3]), .pd_output_analog_pll(pdv[2]),
    .pd_clock_distribution(pdv[1]), .pd_full_device(pdv[0]));
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wt;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1)
    begin
      n_errors++;
      end_sim;
    end
  endtask : wt
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    wt;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask : xfer
  task st;
    repeat (3) @(posedge hclk);
    #1;
  endtask : st
  task t_reset;
    chk(pdv, 8'h00);
    xfer(1'b0, LM, 32'h0);
    chk(rd, 32'h0);
    chk({switchover_mode, manual_ref_b, loop_state}, 6'h00);
    $display("t_reset done");
  endtask : t_reset
  task t_power;
    for (int i = 1; i < 7; i++)
    begin
      xfer(1'b1, PD, 32'h1 << i);
      #1;
      chk(pdv, 32'h1 << i);
      xfer(1'b0, PD, 32'h0);
      chk(rd, 32'h1 << i);
    end
    xfer(1'b1, PD, 32'h01);
    #1;
    chk(pdv, 8'h7F);
    $display("t_power done");
  endtask : t_power
  task t_soft;
    int n;
    n = 0;
    xfer(1'b1, LM, 32'h10);
    xfer(1'b1, PD, 32'hC4);
    repeat (12)
    begin
      #1;
      if (pdv[7] === 1'b1)
        n++;
      @(posedge hclk);
    end
    chk(n, DPLPC_SOFT_RESET_CYCLES);
    chk(pdv, 8'h44);
    xfer(1'b0, PD, 32'h0);
    chk(rd, 32'h44);
    xfer(1'b0, LM, 32'h0);
    chk(rd, 32'h10);
    $display("t_soft done");
  endtask : t_soft
  task t_loop;
    history_valid <= 1'b1;
    xfer(1'b1, LM, 32'h40);
    st;
    chk({loop_state, phase_locked, freq_locked}, 4'h4);
    chk(osc_tw, history_tw);
    history_valid <= 1'b0;
    st;
    chk(osc_tw, freerun_tw);
    history_valid <= 1'b1;
    xfer(1'b1, LM, 32'h60);
    st;
    chk({loop_state, osc_tw}, {2'h2, freerun_tw});
    xfer(1'b1, LM, 32'h0);
    st;
    chk(loop_state, 2'h0);
    chk({phase_locked, freq_locked, osc_tw}, {2'h3, loop_tw});
    xfer(1'b0, {18'h0, DPLPC_ADDR_STATUS}, 32'h0);
    chk(rd, 32'h0C);
    $display("t_loop done");
  endtask : t_loop
  task t_switch;
    logic [2:0] m;
    m = 3'h0;
    for (int c = 0; c < 8; c++)
    begin
      if (c < 5)
        m = c[2:0];
      xfer(1'b1, LM, 32'(c * 4 + 1));
      xfer(1'b0, LM, 32'h0);
      chk(rd, {m, 2'h1});
      chk({switchover_mode, manual_ref_b}, {m, 1'b1});
    end
    xfer(1'b1, LM, 32'hFF);
    xfer(1'b0, LM, 32'h0);
    chk(rd, 32'h71);
    xfer(1'b1, PD + 32'h8, 32'hFF);
    xfer(1'b0, PD + 32'h8, 32'h0);
    chk(rd, 32'h0);
    $display("t_switch done");
  endtask : t_switch
  initial
  begin
    {hresetn, hsel, hwrite, history_valid, phase_lock_raw, freq_lock_raw} = 6'h03;
    {haddr, hwdata, htrans, hsize} = '0;
    {history_tw, freerun_tw, loop_tw} = {24'hABCDE1, 24'h123456, 24'h777777};
    loop_tw_in_valid = 1'b1;
    n_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_power;
    t_soft;
    t_loop;
    t_switch;
    end_sim;
  end
endmodule : dpll_power_and_loop_mode_control_test
`default_nettype wire

// *** dplpc_ahb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module dplpc_ahb_slave
  import dplpc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register side
  dplpc_reg_if.bus rif,
  input wire logic [7:0] status
);
  typedef struct packed
  {
    logic wr;
    logic [13:0] addr;
    logic [31:0] rdata;
  } dplpc_ahb_st_t;

  dplpc_ahb_st_t st;
  dplpc_ahb_st_t next_st;
  logic take;

  always_comb
  begin
    take = hsel && hready && htrans[1] && (hsize == 3'h2);
    next_st = st;
    // Writes above the mapped window must not alias onto the registers
    next_st.wr = take && hwrite && (haddr[31:14] == 18'h00000);
    next_st.addr = haddr[13:0];
    if (take && !hwrite)
    begin
      // Unmapped addresses read as zero
      if (haddr[31:14] != 18'h00000)
        next_st.rdata = 32'h00000000;
      else if (haddr[13:0] == DPLPC_ADDR_POWER_DOWN)
        next_st.rdata = {24'h000000, rif.pd};
      else if (haddr[13:0] == DPLPC_ADDR_LOOP_MODE)
        next_st.rdata = {24'h000000, rif.lm};
      else if (haddr[13:0] == DPLPC_ADDR_STATUS)
        next_st.rdata = {24'h000000, status};
      else
        next_st.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign rif.wr_pd = st.wr && (st.addr == DPLPC_ADDR_POWER_DOWN);
  assign rif.wr_lm = st.wr && (st.addr == DPLPC_ADDR_LOOP_MODE);
  assign rif.wdata = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
endmodule : dplpc_ahb_slave
`default_nettype wire

// *** dplpc_pkg.sv ***
package dplpc_pkg;
  // Offsets are printed as indices (not multiples of four): byte address = 4 * index
  localparam logic [11:0] DPLPC_IDX_POWER_DOWN = 12'hA00;
  localparam logic [11:0] DPLPC_IDX_LOOP_MODE = 12'hA01;
  localparam logic [13:0] DPLPC_ADDR_POWER_DOWN = {DPLPC_IDX_POWER_DOWN, 2'h0};
  localparam logic [13:0] DPLPC_ADDR_LOOP_MODE = {DPLPC_IDX_LOOP_MODE, 2'h0};
  localparam logic [13:0] DPLPC_ADDR_STATUS = 14'h2810;
  // Power-down fields
  localparam int DPLPC_PD_SOFT_RESET = 7;
  localparam int DPLPC_PD_OSC = 6;
  localparam int DPLPC_PD_SYSTEM_CLOCK_INPUT_IN = 5;
  localparam int DPLPC_PD_REF_IN = 4;
  localparam int DPLPC_PD_TDC = 3;
  localparam int DPLPC_PD_OUTPUT_ANALOG_PLL = 2;
  localparam int DPLPC_PD_DIST = 1;
  localparam int DPLPC_PD_FULL = 0;
  // Loop-mode fields
  localparam int DPLPC_LM_HOLDOVER = 6;
  localparam int DPLPC_LM_FREERUN = 5;
  localparam int DPLPC_LM_SW_HI = 4;
  localparam int DPLPC_LM_SW_LO = 2;
  localparam int DPLPC_LM_REF_SEL = 0;
  localparam logic [7:0] DPLPC_LM_WMASK = 8'h7D;
  localparam logic [7:0] DPLPC_PD_RESET = 8'h00;
  localparam logic [7:0] DPLPC_LM_RESET = 8'h00;
  // Soft reset pulse length in cycles
  localparam int DPLPC_SOFT_RESET_CYCLES = 4;

  typedef enum logic [2:0]
  {
    DPLPC_SW_AUTO_REVERT = 3'b000,
    DPLPC_SW_AUTO_NONREV = 3'b001,
    DPLPC_SW_MAN_FALLBACK = 3'b010,
    DPLPC_SW_MAN_HOLDOVER = 3'b011,
    DPLPC_SW_FULL_MANUAL = 3'b100
  } dplpc_sw_mode_t;

  typedef enum logic [1:0]
  {
    DPLPC_LOOP_NORMAL = 2'b00,
    DPLPC_LOOP_HOLDOVER = 2'b01,
    DPLPC_LOOP_FREERUN = 2'b10
  } dplpc_loop_t;
endpackage : dplpc_pkg

// *** dplpc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module dplpc_props
  import dplpc_pkg::*;
#(
  parameter int TW_WIDTH = 24
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Loop
  input wire logic history_valid,
  input wire logic [TW_WIDTH-1:0] history_tw,
  input wire logic [TW_WIDTH-1:0] freerun_tw,
  input wire logic [1:0] loop_state,
  input wire logic [TW_WIDTH-1:0] osc_tw,
  input wire logic phase_locked,
  input wire logic freq_locked,
  // Controls
  input wire logic soft_reset,
  input wire logic pd_controlled_oscillator,
  input wire logic pd_system_clock_input,
  input wire logic pd_reference_inputs,
  input wire logic pd_time_to_digital_converter,
  input wire logic pd_output_analog_pll,
  input wire logic pd_clock_distribution,
  input wire logic pd_full_device
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd(logic [13:0] a);
    hsel && hready && htrans[1] && !hwrite && hsize == 3'h2 && haddr == {18'h0, a};
  endsequence
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_pd_selfclear: assert property (s_rd(DPLPC_ADDR_POWER_DOWN) |=> !hrdata[7])
    else $error("soft reset bit reads back set");
  a_lm_reserved: assert property (s_rd(DPLPC_ADDR_LOOP_MODE) |=>
    !hrdata[7] && !hrdata[1] && hrdata[4:2] <= 3'h4) else $error("loop mode readback bad");
  a_soft_pulse: assert property ($rose(soft_reset) |-> soft_reset[*4] ##1 !soft_reset)
    else $error("soft reset pulse length wrong");
  a_lock_held: assert property ((loop_state != 2'h0)[*2] |-> !phase_locked && !freq_locked)
    else $error("lock shown outside normal loop");
  a_hold_history: assert property ((loop_state == 2'h1 && history_valid && !soft_reset
    && $stable(history_tw))[*2] |-> osc_tw == history_tw) else $error("holdover word wrong");
  a_free_word: assert property ((loop_state == 2'h2 && !soft_reset
    && $stable(freerun_tw))[*2] |-> osc_tw == freerun_tw) else $error("free run word wrong");
  a_full_off: assert property (pd_full_device |-> pd_controlled_oscillator &&
    pd_system_clock_input && pd_reference_inputs && pd_time_to_digital_converter &&
    pd_output_analog_pll && pd_clock_distribution) else $error("full power-down incomplete");
endmodule : dplpc_props
bind dplpc_top dplpc_props #(.TW_WIDTH(TW_WIDTH)) i_dplpc_props (.*);
`default_nettype wire

// *** dplpc_reg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dplpc_reg_if;
  logic wr_pd;
  logic wr_lm;
  logic [7:0] wdata;
  logic [7:0] pd;
  logic [7:0] lm;
  modport bus (output wr_pd, output wr_lm, output wdata, input pd, input lm);
  modport regs (input wr_pd, input wr_lm, input wdata, output pd, output lm);
endinterface : dplpc_reg_if
`default_nettype wire

// *** dplpc_top.sv ***
// How it works
// - Power-down bit 7 pulses an operating-logic reset; register contents survive.
// - Power-down bit 6 sleeps the controlled oscillator; clear after reset.
// - Power-down bit 5 sleeps system clock input and its multiplier PLL.
// - Power-down bit 4 sleeps both reference input receivers.
// - Power-down bit 3 sleeps the time-to-digital converter.
// - Power-down bit 2 sleeps the output analog PLL.
// - Power-down bit 1 sleeps the clock distribution outputs.
// - Power-down bit 0 sleeps the entire device.
// - Loop-mode bit 6 forces holdover; cleared after reset.
// - Forced holdover uses history tuning word if present, else free-run word.
// - Forced holdover holds phase and frequency lock indications unlocked.
// - Loop-mode bit 5 forces free run from the free-run tuning word.
// - Free run beats holdover when both bits are set.
// - Bits 4:2 pick switchover mode, codes 000 to 100; rest unused.
// - Bit 0 picks reference A or B in full manual mode.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dplpc_top
  import dplpc_pkg::*;
#(
  parameter int TW_WIDTH = 24
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Loop inputs, same clock
  input wire logic history_valid,
  input wire logic [TW_WIDTH-1:0] history_tw,
  input wire logic [TW_WIDTH-1:0] freerun_tw,
  input wire logic loop_tw_in_valid,
  input wire logic [TW_WIDTH-1:0] loop_tw,
  input wire logic phase_lock_raw,
  input wire logic freq_lock_raw,
  // Sub-block controls
  output logic soft_reset,
  output logic pd_controlled_oscillator,
  output logic pd_system_clock_input,
  output logic pd_reference_inputs,
  output logic pd_time_to_digital_converter,
  output logic pd_output_analog_pll,
  output logic pd_clock_distribution,
  output logic pd_full_device,
  // Loop control
  output logic [2:0] switchover_mode,
  output logic manual_ref_b,
  output logic [1:0] loop_state,
  output logic [TW_WIDTH-1:0] osc_tw,
  output logic phase_locked,
  output logic freq_locked
);
  if (TW_WIDTH < 1 || TW_WIDTH > 64)
  begin : g_bad_width
    $error("TW_WIDTH out of range");
  end

  typedef struct packed
  {
    logic [7:0] pd;
    logic [7:0] lm;
    logic [2:0] rst_cnt;
    logic [1:0] loop;
    logic [TW_WIDTH-1:0] tw;
    logic plock;
    logic flock;
  } dplpc_top_st_t;

  dplpc_top_st_t st;
  dplpc_top_st_t next_st;
  dplpc_reg_if rif ();
  logic [7:0] status;

  dplpc_ahb_slave u_bus
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rif(rif.bus),
    .status(status)
  );

  assign rif.pd = st.pd;
  assign rif.lm = st.lm;
  assign status = {4'h0, st.plock, st.flock, st.loop};

  always_comb
  begin
    next_st = st;
    if (rif.wr_pd)
    begin
      next_st.pd = rif.wdata;
      next_st.pd[DPLPC_PD_SOFT_RESET] = 1'b0;
    end
    // Other power-down writes must not stall the pulse count
    if (rif.wr_pd && rif.wdata[DPLPC_PD_SOFT_RESET])
      next_st.rst_cnt = 3'(DPLPC_SOFT_RESET_CYCLES);
    else if (st.rst_cnt != 3'h0)
      next_st.rst_cnt = st.rst_cnt - 3'h1;
    if (rif.wr_lm)
    begin
      next_st.lm[DPLPC_LM_HOLDOVER] = rif.wdata[DPLPC_LM_HOLDOVER];
      next_st.lm[DPLPC_LM_FREERUN] = rif.wdata[DPLPC_LM_FREERUN];
      next_st.lm[DPLPC_LM_REF_SEL] = rif.wdata[DPLPC_LM_REF_SEL];
      // Unused codes keep the previous mode
      if (rif.wdata[DPLPC_LM_SW_HI:DPLPC_LM_SW_LO] <= 3'b100)
        next_st.lm[DPLPC_LM_SW_HI:DPLPC_LM_SW_LO] =
          rif.wdata[DPLPC_LM_SW_HI:DPLPC_LM_SW_LO];
    end
    if (st.lm[DPLPC_LM_FREERUN])
      next_st.loop = DPLPC_LOOP_FREERUN;
    else if (st.lm[DPLPC_LM_HOLDOVER])
      next_st.loop = DPLPC_LOOP_HOLDOVER;
    else
      next_st.loop = DPLPC_LOOP_NORMAL;
    case (next_st.loop)
      DPLPC_LOOP_FREERUN:
        next_st.tw = freerun_tw;
      DPLPC_LOOP_HOLDOVER:
        next_st.tw = history_valid ? history_tw : freerun_tw;
      default:
        if (loop_tw_in_valid)
          next_st.tw = loop_tw;
    endcase
    // Lock indications forced low outside normal tracking
    next_st.plock = phase_lock_raw && (next_st.loop == DPLPC_LOOP_NORMAL);
    next_st.flock = freq_lock_raw && (next_st.loop == DPLPC_LOOP_NORMAL);
    // Soft reset clears tuning word and locks but not loop_state or the register bank
    if (st.rst_cnt != 3'h0)
    begin
      next_st.tw = '0;
      next_st.plock = 1'b0;
      next_st.flock = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st.pd <= DPLPC_PD_RESET;
      st.lm <= DPLPC_LM_RESET;
      st.rst_cnt <= 3'h0;
      st.loop <= DPLPC_LOOP_NORMAL;
      st.tw <= '0;
      st.plock <= 1'b0;
      st.flock <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign soft_reset = (st.rst_cnt != 3'h0);
  assign pd_controlled_oscillator = st.pd[DPLPC_PD_OSC] | st.pd[DPLPC_PD_FULL];
  assign pd_system_clock_input = st.pd[DPLPC_PD_SYSTEM_CLOCK_INPUT_IN] | st.pd[DPLPC_PD_FULL];
  assign pd_reference_inputs = st.pd[DPLPC_PD_REF_IN] | st.pd[DPLPC_PD_FULL];
  assign pd_time_to_digital_converter = st.pd[DPLPC_PD_TDC] | st.pd[DPLPC_PD_FULL];
  assign pd_output_analog_pll = st.pd[DPLPC_PD_OUTPUT_ANALOG_PLL] | st.pd[DPLPC_PD_FULL];
  assign pd_clock_distribution = st.pd[DPLPC_PD_DIST] | st.pd[DPLPC_PD_FULL];
  assign pd_full_device = st.pd[DPLPC_PD_FULL];
  assign switchover_mode = st.lm[DPLPC_LM_SW_HI:DPLPC_LM_SW_LO];
  assign manual_ref_b = st.lm[DPLPC_LM_REF_SEL];
  assign loop_state = st.loop;
  assign osc_tw = st.tw;
  assign phase_locked = st.plock;
  assign freq_locked = st.flock;
endmodule : dplpc_top
`default_nettype wire
